/* core/ee_regs.svh */
`ifndef EE_REGS_SVH
`define EE_REGS_SVH

// control code expected in the upper nibble of the control byte
`define EE_CTRL_CODE      4'ha
// array geometry
`define EE_ADDR_W         8
`define EE_DEPTH          256
`define EE_PAGE_BITS      3
`define EE_PAGE_SIZE      8
// smallest variant keeps only the low nibble of the address
`define EE_TINY_MASK      8'h0f
// timing
`define EE_CLK_PERIOD_NS  4
`define EE_WR_CYCLE_NS    5000000

`endif

/* core/ee_pkg.sv */
package ee_pkg;

	// pins sampled from outside the clock domain
	typedef struct packed
	{
		logic scl;
		logic sda;
		logic wp;
		logic sel_high;
		logic sel_mid;
		logic sel_low;
		logic two_byte;
		logic tiny;
	} ee_pins_t;

	typedef enum logic [6:0]
	{
		EE_IDLE  = 7'b0000001,
		EE_CTRL  = 7'b0000010,
		EE_AHI   = 7'b0000100,
		EE_ALO   = 7'b0001000,
		EE_WDATA = 7'b0010000,
		EE_RDATA = 7'b0100000,
		EE_RACK  = 7'b1000000
	} ee_state_t;

endpackage

/* core/ee_slave.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ee_regs.svh"

module ee_slave
#(
	parameter int WR_CYCLE_NS = `EE_WR_CYCLE_NS
)
(
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// two-wire bus
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe,
	// device pins
	input  wire logic wp,
	input  wire logic select_bit_high,
	input  wire logic select_bit_mid,
	input  wire logic select_bit_low,
	// density straps
	input  wire logic two_byte_addr,
	input  wire logic tiny_array,
	// status
	output logic      write_busy
);

	// ****************************************
	// constants and helpers
	// ****************************************
	localparam int WR_CYCLES_RAW = WR_CYCLE_NS / `EE_CLK_PERIOD_NS;
	localparam int WR_CYCLES = (WR_CYCLES_RAW < 1) ? 1 : WR_CYCLES_RAW;

	function automatic logic [`EE_ADDR_W-1:0] fit_addr(input logic [`EE_ADDR_W-1:0] a, input logic tiny);
		fit_addr = tiny ? (a & `EE_TINY_MASK) : a;
	endfunction

	// ****************************************
	// pin synchronisers and edges
	// ****************************************
	ee_pkg::ee_pins_t pin_meta;
	ee_pkg::ee_pins_t pin_sync;
	ee_pkg::ee_pins_t pin_prev;
	ee_pkg::ee_pins_t pin_raw;

	assign pin_raw = '{scl: scl_in, sda: sda_in, wp: wp, sel_high: select_bit_high,
		sel_mid: select_bit_mid, sel_low: select_bit_low, two_byte: two_byte_addr, tiny: tiny_array};

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			pin_meta <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};
			pin_sync <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};
			pin_prev <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};
		end
		else
		begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic ctrl_match;

	assign scl_rise   = pin_sync.scl & ~pin_prev.scl;
	assign scl_fall   = ~pin_sync.scl & pin_prev.scl;
	assign start_seen = pin_sync.scl & pin_prev.scl & pin_prev.sda & ~pin_sync.sda;
	assign stop_seen  = pin_sync.scl & pin_prev.scl & ~pin_prev.sda & pin_sync.sda;

	// ****************************************
	// storage
	// ****************************************
	logic [7:0]              mem [`EE_DEPTH];
	logic [7:0]              page_buf [`EE_PAGE_SIZE];
	logic [`EE_PAGE_SIZE-1:0] page_valid;
	logic [`EE_ADDR_W-1:0]   page_base;
	logic                    wr_pending;
	logic                    wp_latched;
	logic [20:0]             wr_count;

	// ****************************************
	// protocol state
	// ****************************************
	ee_pkg::ee_state_t     state;
	logic [3:0]            bit_cnt;
	logic                  in_ack;
	logic [7:0]            rx_shift;
	logic [7:0]            tx_shift;
	logic                  master_ack;
	logic                  is_read;
	logic [7:0]            addr_hi;
	logic [`EE_ADDR_W-1:0] ptr;
	logic [7:0]            rd_byte;
	logic [`EE_ADDR_W-1:0] next_ptr;
	logic [`EE_ADDR_W-1:0] next_page_ptr;
	logic                  start_write;

	assign ctrl_match = (rx_shift[7:4] == `EE_CTRL_CODE)
		&& (rx_shift[3:1] == {pin_sync.sel_high, pin_sync.sel_mid, pin_sync.sel_low});
	assign rd_byte       = mem[ptr];
	assign next_ptr      = fit_addr(ptr + 8'h01, pin_sync.tiny);
	assign next_page_ptr = fit_addr({ptr[`EE_ADDR_W-1:`EE_PAGE_BITS],
		ptr[`EE_PAGE_BITS-1:0] + 3'h1}, pin_sync.tiny);
	assign start_write   = stop_seen && wr_pending && !wp_latched;

	// open drain: only ever pulls low
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			sda_out <= 1'b0;
		else
			sda_out <= 1'b0;
	end

	// bit engine and byte handling
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state      <= ee_pkg::EE_IDLE;
			bit_cnt    <= 4'h0;
			in_ack     <= 1'b0;
			rx_shift   <= 8'h00;
			tx_shift   <= 8'h00;
			master_ack <= 1'b0;
			is_read    <= 1'b0;
			addr_hi    <= 8'h00;
			ptr        <= 8'h00;
			sda_oe     <= 1'b0;
		end
		else if (start_seen)
		begin
			state   <= ee_pkg::EE_CTRL;
			bit_cnt <= 4'h0;
			in_ack  <= 1'b0;
			sda_oe  <= 1'b0;
		end
		else if (stop_seen)
		begin
			state  <= ee_pkg::EE_IDLE;
			in_ack <= 1'b0;
			sda_oe <= 1'b0;
		end
		else
		begin
			case (state)
				ee_pkg::EE_CTRL, ee_pkg::EE_AHI, ee_pkg::EE_ALO, ee_pkg::EE_WDATA:
				begin
					if (scl_rise && !in_ack && bit_cnt != 4'h8)
					begin
						rx_shift <= {rx_shift[6:0], pin_sync.sda};
						bit_cnt  <= bit_cnt + 4'h1;
					end
					else if (scl_fall && !in_ack && bit_cnt == 4'h8)
					begin
						in_ack <= 1'b1;
						sda_oe <= 1'b1;
						case (state)
							ee_pkg::EE_CTRL:
							begin
								is_read <= rx_shift[0];
								if (!ctrl_match || write_busy)
								begin
									sda_oe <= 1'b0;
									in_ack <= 1'b0;
									state  <= ee_pkg::EE_IDLE;
								end
							end
							ee_pkg::EE_AHI:
								addr_hi <= rx_shift;
							ee_pkg::EE_ALO:
								ptr <= fit_addr(rx_shift, pin_sync.tiny);
							ee_pkg::EE_WDATA:
								ptr <= next_page_ptr;
							default:
								sda_oe <= 1'b0;
						endcase
					end
					else if (scl_fall && in_ack)
					begin
						in_ack  <= 1'b0;
						bit_cnt <= 4'h0;
						sda_oe  <= 1'b0;
						case (state)
							ee_pkg::EE_CTRL:
							begin
								if (is_read)
								begin
									state    <= ee_pkg::EE_RDATA;
									sda_oe   <= ~rd_byte[7];
									tx_shift <= {rd_byte[6:0], 1'b0};
									bit_cnt  <= 4'h1;
									ptr      <= next_ptr;
								end
								else if (pin_sync.two_byte)
									state <= ee_pkg::EE_AHI;
								else
									state <= ee_pkg::EE_ALO;
							end
							ee_pkg::EE_AHI:
								state <= ee_pkg::EE_ALO;
							default:
								state <= ee_pkg::EE_WDATA;
						endcase
					end
				end
				ee_pkg::EE_RDATA:
				begin
					if (scl_fall)
					begin
						if (bit_cnt != 4'h8)
						begin
							sda_oe   <= ~tx_shift[7];
							tx_shift <= {tx_shift[6:0], 1'b0};
							bit_cnt  <= bit_cnt + 4'h1;
						end
						else
						begin
							sda_oe <= 1'b0;
							state  <= ee_pkg::EE_RACK;
						end
					end
				end
				ee_pkg::EE_RACK:
				begin
					if (scl_rise)
						master_ack <= ~pin_sync.sda;
					else if (scl_fall)
					begin
						if (master_ack)
						begin
							state    <= ee_pkg::EE_RDATA;
							sda_oe   <= ~rd_byte[7];
							tx_shift <= {rd_byte[6:0], 1'b0};
							bit_cnt  <= 4'h1;
							ptr      <= next_ptr;
						end
						else
							state <= ee_pkg::EE_IDLE;
					end
				end
				ee_pkg::EE_IDLE:
					sda_oe <= 1'b0;
				default:
				begin
					state  <= ee_pkg::EE_IDLE;
					sda_oe <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// page buffer and protect sampling
	// ****************************************
	logic data_taken;
	logic ctrl_taken;

	assign data_taken = (state == ee_pkg::EE_WDATA) && scl_fall && !in_ack && bit_cnt == 4'h8;
	assign ctrl_taken = (state == ee_pkg::EE_CTRL) && scl_fall && !in_ack && bit_cnt == 4'h8
		&& ctrl_match && !write_busy && !rx_shift[0];

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			page_valid <= '0;
			page_base  <= 8'h00;
			wr_pending <= 1'b0;
			wp_latched <= 1'b0;
		end
		else if (ctrl_taken)
		begin
			page_valid <= '0;
			wr_pending <= 1'b0;
		end
		else if (data_taken)
		begin
			page_valid[ptr[`EE_PAGE_BITS-1:0]] <= 1'b1;
			page_base  <= ptr;
			wr_pending <= 1'b1;
			wp_latched <= pin_sync.wp;
		end
		else if (stop_seen)
			wr_pending <= 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (data_taken)
			page_buf[ptr[`EE_PAGE_BITS-1:0]] <= rx_shift;
	end

	// commit only the entries that received data
	always_ff @(posedge mclk)
	begin
		if (start_write)
		begin
			for (int i = 0; i < `EE_PAGE_SIZE; i++)
			begin
				if (page_valid[i])
					mem[{page_base[`EE_ADDR_W-1:`EE_PAGE_BITS], 3'(i)}] <= page_buf[i];
			end
		end
	end

	// ****************************************
	// self-timed write cycle
	// ****************************************
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			write_busy <= 1'b0;
			wr_count   <= 21'h000000;
		end
		else if (start_write)
		begin
			write_busy <= 1'b1;
			wr_count   <= 21'(WR_CYCLES - 1);
		end
		else if (write_busy)
		begin
			if (wr_count == 21'h000000)
				write_busy <= 1'b0;
			else
				wr_count <= wr_count - 21'h000001;
		end
	end

endmodule
`default_nettype wire

/* tb/ee_slave_props.sv */
`timescale 1ns/1ns
`default_nettype none
// ****
// bus and write cycle checks
// ****
module ee_slave_props
#(
	parameter int WR_CYCLE_NS = 400
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// bus and pins
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic wp,
	input wire logic write_busy
);
	localparam int CYC = WR_CYCLE_NS / 4;
	logic [31:0] bc;
	// length of the current busy stretch
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			bc <= 32'h0;
		else
			bc <= write_busy ? bc + 32'h1 : 32'h0;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	property p_sda_low; sda_out == 1'b0; endproperty
	property p_busy_len; $fell(write_busy) |-> bc == CYC; endproperty
	property p_busy_quiet; write_busy |-> !sda_oe; endproperty
	property p_busy_stop; $rose(write_busy) |-> scl_in && sda_in; endproperty
	property p_busy_gap; $fell(write_busy) |=> !write_busy [*8]; endproperty
	property p_wp_late; write_busy && $changed(wp) |=> write_busy; endproperty
	property p_oe_scl; $changed(sda_oe) |-> !scl_in; endproperty
	property p_oe_pulse; $rose(sda_oe) |-> sda_oe [*8] ##[1:290] !sda_oe; endproperty
	a_sda_low: assert property (p_sda_low) else $error("sda out high");
	a_busy_len: assert property (p_busy_len) else $error("busy length");
	a_busy_quiet: assert property (p_busy_quiet) else $error("ack while busy");
	a_busy_stop: assert property (p_busy_stop) else $error("busy without stop");
	a_busy_gap: assert property (p_busy_gap) else $error("busy restarted");
	a_wp_late: assert property (p_wp_late) else $error("late wp cut cycle");
	a_oe_scl: assert property (p_oe_scl) else $error("sda moved, scl high");
	a_oe_pulse: assert property (p_oe_pulse) else $error("sda drive length");
	c_busy: cover property ($fell(write_busy));
	c_ack: cover property ($rose(sda_oe));
	c_wp: cover property (write_busy && $changed(wp));
endmodule

bind ee_slave ee_slave_props #(.WR_CYCLE_NS(WR_CYCLE_NS)) props_u
(
	.mclk(mclk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .wp(wp), .write_busy(write_busy)
);
`default_nettype wire

/* tb/ee_bus_master.sv */
`timescale 1ns/1ns
`default_nettype none
// ****
// bit-banging bus master, 31 mclk per bit
// ****
module ee_bus_master
(
	// clock
	input  wire logic mclk,
	// bus
	input  wire logic sda_bus,
	output var  logic scl,
	output var  logic sda_pull
);
	initial
	begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// also serves as repeated start
	task automatic start();
		sda_pull = 1'b0;
		tick(8);
		scl = 1'b1;
		tick(8);
		sda_pull = 1'b1;
		tick(8);
		scl = 1'b0;
		tick(7);
	endtask
	task automatic stop();
		sda_pull = 1'b1;
		tick(8);
		scl = 1'b1;
		tick(8);
		sda_pull = 1'b0;
		tick(8);
	endtask
	task automatic bit_io(input logic b, output logic r);
		sda_pull = !b;
		tick(8);
		scl = 1'b1;
		tick(8);
		r = sda_bus;
		tick(8);
		scl = 1'b0;
		tick(7);
	endtask
	task automatic xfer(input logic [7:0] w, input logic m9, output logic [7:0] r, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(w[i], b);
			r[i] = b;
		end
		bit_io(m9, b);
		ack = !b;
	endtask
endmodule
`default_nettype wire

/* tb/ee_slave_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ee_regs.svh"
// ****
// bench
// ****
module ee_slave_tb;
	logic        mclk;
	logic        rst;
	logic        wp;
	logic        two_b;
	logic        tiny;
	logic [2:0]  sel;
	logic        scl;
	logic        pull;
	logic        oe;
	logic        busy;
	wire         sda;
	logic [7:0]  ref_mem [256];
	logic [7:0]  cur;
	logic [7:0]  a;
	int          fail_count;
	int          checks_done;
	int          tn;
	int unsigned seed;
	// pull-up on the data line
	assign sda = !(pull | oe);
	ee_bus_master m_u (.mclk(mclk), .sda_bus(sda), .scl(scl), .sda_pull(pull));
	ee_slave #(.WR_CYCLE_NS(4000)) dut_u
	(
		.mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(oe), .wp(wp),
		.select_bit_high(sel[2]), .select_bit_mid(sel[1]), .select_bit_low(sel[0]),
		.two_byte_addr(two_b), .tiny_array(tiny), .write_busy(busy)
	);
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e || $isunknown(e))
		begin
			fail_count++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic tend();
		tn++;
		$display("test %0d done", tn);
	endtask
	function automatic logic [7:0] cb(input logic rw);
		return {`EE_CTRL_CODE, sel, rw};
	endfunction
	task automatic ctrl(input logic [7:0] c, input logic exp);
		logic [7:0] r;
		logic       ack;
		m_u.start();
		m_u.xfer(c, 1'b1, r, ack);
		chk(8'(ack), 8'(exp));
	endtask
	task automatic send(input logic [7:0] a);
		logic [7:0] r;
		logic       ack;
		if (two_b)
		begin
			m_u.xfer(8'($urandom), 1'b1, r, ack);
			chk(8'(ack), 8'h01);
		end
		m_u.xfer(a, 1'b1, r, ack);
		chk(8'(ack), 8'h01);
	endtask
	task automatic poll();
		logic [7:0] r;
		logic       ack;
		int         n;
		n = 0;
		ack = 1'b0;
		while (!ack && n < 20)
		begin
			m_u.start();
			m_u.xfer(cb(1'b0), 1'b1, r, ack);
			n++;
		end
		m_u.stop();
		chk(8'(n > 1), 8'h01);
		chk(8'(ack), 8'h01);
		if (!ack)
			wrap_up();
	endtask
	task automatic wr(input logic [7:0] a, input int n, input logic late);
		logic [7:0] d;
		logic [7:0] r;
		logic       ack;
		ctrl(cb(1'b0), 1'b1);
		send(a);
		for (int i = 0; i < n; i++)
		begin
			d = 8'($urandom);
			m_u.xfer(d, 1'b1, r, ack);
			chk(8'(ack), 8'h01);
			if (!wp)
				ref_mem[{a[7:3], a[2:0] + 3'(i)}] = d;
		end
		m_u.stop();
		cur = {a[7:3], a[2:0] + 3'(n)};
		if (wp)
		begin
			chk(8'(busy), 8'h00);
			ctrl(cb(1'b0), 1'b1);
			m_u.stop();
		end
		else
		begin
			wp = late;
			poll();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic rnd, input int n, input logic [7:0] e);
		logic [7:0] r;
		logic       ack;
		if (rnd)
		begin
			ctrl(cb(1'b0), 1'b1);
			send(a);
		end
		ctrl(cb(1'b1), 1'b1);
		for (int i = 0; i < n; i++)
		begin
			m_u.xfer(8'hff, i == n - 1, r, ack);
			chk(r, ref_mem[e]);
			e = e + 8'h01;
		end
		m_u.stop();
		cur = e;
	endtask
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	initial
	begin
		repeat (90000) @(posedge mclk);
		fail_count++;
		$display("[ERR] t=%0t cycles %h limit %h", $time, 32'd90000, 32'd90000);
		wrap_up();
	end
	initial
	begin
		rst = 1'b1;
		wp = 1'b0;
		two_b = 1'b0;
		tiny = 1'b0;
		fail_count = 0;
		checks_done = 0;
		tn = 0;
		seed = $urandom(81);
		sel = 3'($urandom);
		repeat (5) @(posedge mclk);
		#1;
		rst = 1'b0;
		m_u.tick(4);
		for (int i = 0; i < 2; i++)
			ctrl(i ? {4'h5, sel, 1'b0} : {`EE_CTRL_CODE, ~sel, 1'b0}, 1'b0);
		m_u.stop();
		tend();
		two_b = 1'b1;
		wr(8'hfd, 10, 1'b0);
		wr(8'hfe, 3, 1'b0);
		two_b = 1'b0;
		wr(8'h00, 1, 1'b0);
		tend();
		wr(8'hfa, 1, 1'b0);
		rd(8'h00, 1'b0, 1, cur);
		wp = 1'b1;
		wr(8'hfb, 1, 1'b0);
		wp = 1'b0;
		wr(8'hfc, 1, 1'b1);
		wp = 1'b0;
		tend();
		two_b = 1'b1;
		rd(8'hf8, 1'b1, 9, 8'hf8);
		two_b = 1'b0;
		tiny = 1'b1;
		rd(8'hf0, 1'b1, 1, 8'h00);
		tiny = 1'b0;
		tend();
		for (int k = 0; k < 3; k++)
		begin
			a = 8'($urandom);
			a[2:0] = 3'($urandom % 7);
			wr(a, 2, 1'b0);
			rd(a, 1'b1, 1, a);
			rd(8'h00, 1'b0, 1, cur);
		end
		tend();
		wrap_up();
	end
endmodule
`default_nettype wire
